// ### core/lds_defs.svh
// Purpose: Shared constants for the LED driver stage protection core
// Assumes: 20 MHz core clock
// Notes: Times in ns; cycle counts are derived where used
`ifndef LDS_DEFS_SVH
`define LDS_DEFS_SVH

// ----------------------------------------
// Clock and protection times
// ----------------------------------------
`define LDS_CLK_NS 50
`define LDS_BOP_NS 1600000
`define LDS_COP_NS 13800000
`define LDS_RESTART_NS 1000000000
`define LDS_TON_MAX_NS 50000

// ----------------------------------------
// Clamp duty averaging weights (49 percent)
// ----------------------------------------
`define LDS_COP_UP 51
`define LDS_COP_DN 49

// ----------------------------------------
// Widths
// ----------------------------------------
`define LDS_AVG_W 25
`define LDS_RST_W 25
`define LDS_T_W 12
`define LDS_ACC_W 32
`define LDS_DIM_W 8
`define LDS_CNT_W 18

// ----------------------------------------
// Dim scaling
// ----------------------------------------
`define LDS_DIM_FULL 8'hFF
`define LDS_DIM_MIN 8'h05
`define LDS_DIM_SHIFT 10

`endif

// ### core/lds_pkg.sv
// Purpose: Types for the LED driver stage protection core
// Assumes: Nothing
// Notes: None
package lds_pkg;
    typedef enum logic {LDS_FLYBACK, LDS_BUCK} lds_topo_t;
    typedef enum {S_IDLE, S_ON, S_DEMAG, S_WAIT} lds_state_t;
endpackage

// ### core/lds_sync.sv
// Purpose: Three-stage input synchroniser with agreement filter
// Assumes: Inputs asynchronous to mclk_i
// Notes: Output moves only when stages two and three agree
`timescale 1ns/1ps
module lds_sync #(
    parameter int W = 1
) (
    input wire logic mclk_i,
    input wire logic srst_i,
    input wire logic [W-1:0] in_i,
    output logic [W-1:0] out_o
);
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] next_out;

    always_comb begin
        next_out = (~(s2 ^ s3) & s2) | ((s2 ^ s3) & out_o);
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
            out_o <= '0;
        end else begin
            s1 <= in_i;
            s2 <= s1;
            s3 <= s2;
            out_o <= next_out;
        end
    end
endmodule

// ### core/lds_avg.sv
// Purpose: Leaky up/down averager with trip threshold
// Assumes: sample_i on mclk_i
// Notes: Saturates at both ends
`timescale 1ns/1ps
module lds_avg #(
    parameter int W = 25,
    parameter logic [W-1:0] UP = 1,
    parameter logic [W-1:0] DN = 1,
    parameter logic [W-1:0] TRIP = 1
) (
    input wire logic mclk_i,
    input wire logic srst_i,
    input wire logic sample_i,
    output logic trip_o
);
    logic [W-1:0] avg;
    logic [W-1:0] next_avg;

    always_comb begin
        if (sample_i) begin
            next_avg = (avg > ~UP) ? '1 : avg + UP;
        end else begin
            next_avg = (avg < DN) ? '0 : avg - DN;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            avg <= '0;
            trip_o <= 1'b0;
        end else begin
            avg <= next_avg;
            trip_o <= next_avg >= TRIP;
        end
    end
endmodule

// ### core/lds_top.sv
// Purpose: Boost, clamp and second-stage control with protection
// Assumes: Analog thresholds are external comparators; settings static
// Notes: One clock, synchronous reset
// Function
// - Boost aux sense is boost zero-current detect
// - Boost overvoltage comparator raises boost fault
// - Average boost fault; disable boost within 1.6ms
// - During boost event keep stage, dim full
// - Re-enable boost at recovery voltage
// - Clamp PWM holds boost below clamp level
// - Clamp average over 49% stops both stages
// - Clamp drive off during clamp overpower
// - Clamp continuous on limited to 13.8ms
// - Dim from conduction time, linear 2-100%
// - Gate off at peak current threshold
// - Measure demag, compute period, schedule turn-on
// - Flyback period: peak times demag times gain/dim
// - Buck period: peak times on+demag times gain/dim
// - Wait for demagnetization before new conduction
// - Aux overvoltage disables output, restart 1s
// - Overcurrent disables output, restart 1s
// - On time of 50us or more disables output, restart 1s
// - Die overtemp stops switching with hysteresis
`timescale 1ns/1ps
`include "lds_defs.svh"
module lds_top #(
    parameter int BOP_CYC = `LDS_BOP_NS / `LDS_CLK_NS,
    parameter int COP_CYC = `LDS_COP_NS / `LDS_CLK_NS,
    parameter int RESTART_CYC = `LDS_RESTART_NS / `LDS_CLK_NS
) (
    input wire logic mclk_i,
    input wire logic srst_i,
    input wire lds_pkg::lds_topo_t topology_i,
    input wire logic [`LDS_DIM_W-1:0] ipk_code_i,
    input wire logic [`LDS_DIM_W-1:0] period_gain_setting_i,
    input wire logic boost_aux_sense_i,
    input wire logic boost_ovp_cmp_i,
    input wire logic boost_rec_cmp_i,
    input wire logic clamp_cmp_i,
    input wire logic second_stage_aux_sense_i,
    input wire logic zero_current_detect_i,
    input wire logic cs_peak_i,
    input wire logic cs_ocp_i,
    input wire logic cs_olp_i,
    input wire logic die_hot_i,
    input wire logic die_cool_i,
    input wire logic dim_conduct_i,
    input wire logic half_line_i,
    output logic gate_drive_out_o,
    output logic boost_en_o,
    output logic boost_zcd_o,
    output logic clamp_drive_o,
    output logic [`LDS_DIM_W-1:0] dim_level_o,
    output logic boost_overvoltage_fault_o,
    output logic clamp_overpower_fault_o,
    output logic output_overvoltage_fault_o,
    output logic overcurrent_fault_o,
    output logic open_loop_fault_o,
    output logic die_overtemp_fault_o
);
    import lds_pkg::*;

    localparam int TON_MAX = `LDS_TON_MAX_NS / `LDS_CLK_NS;
    localparam logic [`LDS_RST_W-1:0] RST_LOAD = `LDS_RST_W'(RESTART_CYC);

    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    logic s_baux, s_bovp, s_brec, s_clamp, s_aovp, s_zcd;
    logic s_peak, s_ocp, s_olp, s_hot, s_cool, s_cond, s_half;

    lds_sync #(.W(13)) u_sync (
        .mclk_i(mclk_i),
        .srst_i(srst_i),
        .in_i({boost_aux_sense_i, boost_ovp_cmp_i, boost_rec_cmp_i, clamp_cmp_i,
               second_stage_aux_sense_i, zero_current_detect_i, cs_peak_i, cs_ocp_i,
               cs_olp_i, die_hot_i, die_cool_i, dim_conduct_i, half_line_i}),
        .out_o({s_baux, s_bovp, s_brec, s_clamp, s_aovp, s_zcd,
                s_peak, s_ocp, s_olp, s_hot, s_cool, s_cond, s_half})
    );

    // ----------------------------------------
    // Fault averagers
    // ----------------------------------------
    logic bop_trip;
    logic cop_trip;

    lds_avg #(
        .W(`LDS_AVG_W),
        .UP(`LDS_AVG_W'(1)),
        .DN(`LDS_AVG_W'(1)),
        .TRIP(`LDS_AVG_W'(BOP_CYC))
    ) u_bop_avg (
        .mclk_i(mclk_i),
        .srst_i(srst_i),
        .sample_i(s_bovp),
        .trip_o(bop_trip)
    );

    lds_avg #(
        .W(`LDS_AVG_W),
        .UP(`LDS_AVG_W'(`LDS_COP_UP)),
        .DN(`LDS_AVG_W'(`LDS_COP_DN)),
        .TRIP(`LDS_AVG_W'(COP_CYC * `LDS_COP_UP))
    ) u_cop_avg (
        .mclk_i(mclk_i),
        .srst_i(srst_i),
        .sample_i(clamp_drive_o),
        .trip_o(cop_trip)
    );

    // ----------------------------------------
    // Dim extraction
    // ----------------------------------------
    logic [`LDS_CNT_W-1:0] cond_cnt, next_cond_cnt, cnt_sh;
    logic [`LDS_DIM_W-1:0] dim_meas, next_dim_meas, next_dim;
    logic half_q;
    logic bop_evt, next_bop;

    always_comb begin
        next_cond_cnt = cond_cnt;
        next_dim_meas = dim_meas;
        cnt_sh = cond_cnt >> `LDS_DIM_SHIFT;
        if (s_half && !half_q) begin
            next_cond_cnt = '0;
            if (cnt_sh > `LDS_CNT_W'(`LDS_DIM_FULL)) begin
                next_dim_meas = `LDS_DIM_FULL;
            end else if (cnt_sh < `LDS_CNT_W'(`LDS_DIM_MIN)) begin
                next_dim_meas = `LDS_DIM_MIN;
            end else begin
                next_dim_meas = cnt_sh[`LDS_DIM_W-1:0];
            end
        end else if (s_cond && cond_cnt != '1) begin
            next_cond_cnt = cond_cnt + 1'b1;
        end
        next_dim = next_bop ? `LDS_DIM_FULL : next_dim_meas;
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            cond_cnt <= '0;
            dim_meas <= `LDS_DIM_FULL;
            half_q <= 1'b0;
            dim_level_o <= `LDS_DIM_FULL;
        end else begin
            cond_cnt <= next_cond_cnt;
            dim_meas <= next_dim_meas;
            half_q <= s_half;
            dim_level_o <= next_dim;
        end
    end

    // ----------------------------------------
    // Protection and restart
    // ----------------------------------------
    lds_state_t state, next_state;
    logic [`LDS_T_W-1:0] t1, next_t1, t2, next_t2;
    logic [`LDS_RST_W-1:0] rcnt, next_rcnt;
    logic next_otp, next_cop, next_ovp, next_ocp, next_olp, next_run;
    logic f_ovp, f_ocp, f_olp, any_new, expire, stage_fault;

    always_comb begin
        next_bop = bop_evt;
        if (bop_trip) begin
            next_bop = 1'b1;
        end else if (s_brec) begin
            next_bop = 1'b0;
        end
        next_otp = die_overtemp_fault_o;
        if (s_hot) begin
            next_otp = 1'b1;
        end else if (s_cool) begin
            next_otp = 1'b0;
        end
        f_ovp = s_aovp && state != S_IDLE;
        f_ocp = s_ocp;
        f_olp = state == S_ON && t1 >= `LDS_T_W'(TON_MAX);
        any_new = f_ovp || f_ocp || f_olp || cop_trip;
        expire = rcnt == `LDS_RST_W'(1) && !any_new;
        next_rcnt = rcnt;
        if (any_new) begin
            next_rcnt = RST_LOAD;
        end else if (rcnt != '0) begin
            next_rcnt = rcnt - 1'b1;
        end
        next_ovp = (output_overvoltage_fault_o && !expire) || f_ovp;
        next_ocp = (overcurrent_fault_o && !expire) || f_ocp;
        next_olp = (open_loop_fault_o && !expire) || f_olp;
        next_cop = (clamp_overpower_fault_o && !expire) || cop_trip;
        stage_fault = next_ovp || next_ocp || next_olp;
        next_run = !(next_cop || next_otp || stage_fault);
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            bop_evt <= 1'b0;
            rcnt <= '0;
            die_overtemp_fault_o <= 1'b0;
            output_overvoltage_fault_o <= 1'b0;
            overcurrent_fault_o <= 1'b0;
            open_loop_fault_o <= 1'b0;
            clamp_overpower_fault_o <= 1'b0;
            boost_overvoltage_fault_o <= 1'b0;
            boost_en_o <= 1'b0;
            clamp_drive_o <= 1'b0;
            boost_zcd_o <= 1'b0;
        end else begin
            bop_evt <= next_bop;
            rcnt <= next_rcnt;
            die_overtemp_fault_o <= next_otp;
            output_overvoltage_fault_o <= next_ovp;
            overcurrent_fault_o <= next_ocp;
            open_loop_fault_o <= next_olp;
            clamp_overpower_fault_o <= next_cop;
            boost_overvoltage_fault_o <= next_bop;
            boost_en_o <= next_run && !next_bop;
            clamp_drive_o <= s_clamp && !next_cop;
            boost_zcd_o <= s_baux;
        end
    end

    // ----------------------------------------
    // Quasi-resonant second stage
    // ----------------------------------------
    logic [`LDS_ACC_W-1:0] acc, next_acc, tgt, next_tgt, dim_ext;
    logic [`LDS_T_W:0] tsum;
    logic next_gate;

    always_comb begin
        next_state = state;
        next_t1 = t1;
        next_t2 = t2;
        next_tgt = tgt;
        next_gate = 1'b0;
        dim_ext = `LDS_ACC_W'(dim_level_o);
        next_acc = acc + dim_ext;
        tsum = (topology_i == LDS_BUCK) ? {1'b0, t1} + {1'b0, t2} : {1'b0, t2};
        if (!next_run) begin
            next_state = S_IDLE;
            next_acc = '0;
        end else begin
            unique case (state)
                S_IDLE: begin
                    next_state = S_ON;
                    next_gate = 1'b1;
                    next_t1 = '0;
                    next_acc = '0;
                end
                S_ON: begin
                    next_t1 = t1 + 1'b1;
                    next_gate = 1'b1;
                    if (s_peak) begin
                        next_gate = 1'b0;
                        next_state = S_DEMAG;
                        next_t2 = '0;
                    end
                end
                S_DEMAG: begin
                    if (t2 != '1) begin
                        next_t2 = t2 + 1'b1;
                    end
                    if (s_zcd) begin
                        next_state = S_WAIT;
                        next_tgt = `LDS_ACC_W'(ipk_code_i) * `LDS_ACC_W'(tsum)
                                   * `LDS_ACC_W'(period_gain_setting_i);
                    end
                end
                S_WAIT: begin
                    if (acc >= tgt) begin
                        next_state = S_ON;
                        next_gate = 1'b1;
                        next_t1 = '0;
                        next_acc = '0;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            state <= S_IDLE;
            t1 <= '0;
            t2 <= '0;
            acc <= '0;
            tgt <= '0;
            gate_drive_out_o <= 1'b0;
        end else begin
            state <= next_state;
            t1 <= next_t1;
            t2 <= next_t2;
            acc <= next_acc;
            tgt <= next_tgt;
            gate_drive_out_o <= next_gate;
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (srst_i);

    property p_gate_peak;
        state == S_ON && s_peak && next_run |=> !gate_drive_out_o && state == S_DEMAG;
    endproperty
    a_gate_peak: assert property (p_gate_peak) else $error("gate not off at peak");

    property p_ocp;
        state == S_ON && s_ocp |=> overcurrent_fault_o && !gate_drive_out_o && rcnt == RST_LOAD;
    endproperty
    a_ocp: assert property (p_ocp) else $error("overcurrent not handled");

    property p_ovp;
        s_aovp && state != S_IDLE |=> output_overvoltage_fault_o && !boost_en_o;
    endproperty
    a_ovp: assert property (p_ovp) else $error("output overvoltage not handled");

    property p_olp;
        state == S_ON && t1 == `LDS_T_W'(TON_MAX) |=> open_loop_fault_o && state == S_IDLE;
    endproperty
    a_olp: assert property (p_olp) else $error("open loop not flagged");

    property p_restart;
        any_new |=> rcnt == RST_LOAD;
    endproperty
    a_restart: assert property (p_restart) else $error("restart count not reloaded");

    property p_bop;
        bop_trip |=> !boost_en_o && boost_overvoltage_fault_o;
    endproperty
    a_bop: assert property (p_bop) else $error("boost not disabled on overvoltage");

    property p_bop_dim;
        bop_evt |-> dim_level_o == `LDS_DIM_FULL;
    endproperty
    a_bop_dim: assert property (p_bop_dim) else $error("dim not full in boost event");

    property p_bop_rec;
        bop_evt && s_brec && !bop_trip |=> !boost_overvoltage_fault_o;
    endproperty
    a_bop_rec: assert property (p_bop_rec) else $error("boost event not cleared");

    property p_cop;
        cop_trip |=> clamp_overpower_fault_o && !gate_drive_out_o && !boost_en_o;
    endproperty
    a_cop: assert property (p_cop) else $error("clamp overpower not handled");

    property p_clamp_off;
        clamp_overpower_fault_o |-> !clamp_drive_o;
    endproperty
    a_clamp_off: assert property (p_clamp_off) else $error("clamp on during overpower");

    property p_otp;
        die_overtemp_fault_o |-> !gate_drive_out_o && !boost_en_o;
    endproperty
    a_otp: assert property (p_otp) else $error("switching during overtemp");

    property p_dim_min;
        !bop_evt |-> dim_level_o >= `LDS_DIM_MIN;
    endproperty
    a_dim_min: assert property (p_dim_min) else $error("dim below minimum");

    c_turn_on: cover property (state == S_WAIT ##1 state == S_ON);
    c_bop: cover property (bop_evt ##[1:300] !bop_evt);
    c_cop: cover property ($rose(clamp_overpower_fault_o));
    c_expire: cover property (expire);
endmodule

// ### verif/lds_power_model.sv
// Purpose: Behavioural power stage behind the second-stage sense comparators
// Assumes: Comparator outputs are push-pull, low when not tripped
// Notes: Peak arrives on_len+1 cycles after turn-on, demag ends dm_len+1 cycles after turn-off
`timescale 1ns/1ps
module lds_power_model (
    input wire logic mclk_i,
    input wire logic gate_i,
    input wire logic no_current_i,
    input wire logic [7:0] on_len_i,
    input wire logic [7:0] dm_len_i,
    output logic cs_peak_o,
    output logic above_min_o,
    output logic demag_done_o
);
    logic [7:0] on_cnt = 8'h00;
    logic [7:0] off_cnt = 8'h00;

    initial begin
        cs_peak_o = 1'b0;
        demag_done_o = 1'b0;
    end

    // ----------------------------------------
    // Inductor current and demagnetization
    // ----------------------------------------
    always @(posedge mclk_i) begin
        if (gate_i) begin
            off_cnt <= 8'h00;
            demag_done_o <= 1'b0;
            if (on_cnt < on_len_i) begin
                on_cnt <= on_cnt + 8'h01;
            end
            cs_peak_o <= !no_current_i && (on_cnt >= on_len_i);
        end else begin
            on_cnt <= 8'h00;
            cs_peak_o <= 1'b0;
            if (off_cnt < dm_len_i) begin
                off_cnt <= off_cnt + 8'h01;
            end
            demag_done_o <= (off_cnt >= dm_len_i);
        end
    end

    // Sense stays under the minimum level when the current path is broken
    assign above_min_o = gate_i && !no_current_i;
endmodule

// ### verif/tb_led_driver_stage_protection.sv
// Purpose: Self-checking bench for the LED driver stage protection core
// Assumes: Shortened averaging and restart counts
// Notes: Inputs change on the falling clock edge
`timescale 1ns/1ps
module tb_led_driver_stage_protection;
    import lds_pkg::*;
    localparam int BOOST_AVG = 20;
    localparam int CLAMP_AVG = 20;
    localparam int RESTART = 50;
    localparam int CEIL = 90000;
    logic mclk_i = 1'b0;
    logic srst_i = 1'b1;
    lds_topo_t topo = LDS_FLYBACK;
    logic [7:0] gain = 8'h32;
    logic [7:0] ipk = 8'h64;
    logic boost_aux = 1'b0, boost_high = 1'b0, boost_low = 1'b0, clamp_high = 1'b0, aux_high = 1'b0;
    logic cur_high = 1'b0, hot = 1'b0, cool = 1'b1, cond = 1'b0, hline = 1'b0, no_cur = 1'b0;
    logic cs_peak, above_min, demag_done;
    logic [9:0] mon;
    logic [7:0] dim;
    int err_total = 0;
    int total_checks = 0;
    int cyc = 0;
    int f50 = 0;

    always #25 mclk_i = ~mclk_i;

    lds_top #(.BOP_CYC(BOOST_AVG), .COP_CYC(CLAMP_AVG), .RESTART_CYC(RESTART)) uut (
        .mclk_i(mclk_i), .srst_i(srst_i), .topology_i(topo), .ipk_code_i(ipk),
        .period_gain_setting_i(gain), .boost_aux_sense_i(boost_aux), .boost_ovp_cmp_i(boost_high),
        .boost_rec_cmp_i(boost_low), .clamp_cmp_i(clamp_high), .second_stage_aux_sense_i(aux_high),
        .zero_current_detect_i(demag_done), .cs_peak_i(cs_peak), .cs_ocp_i(cur_high),
        .cs_olp_i(above_min), .die_hot_i(hot), .die_cool_i(cool), .dim_conduct_i(cond),
        .half_line_i(hline), .gate_drive_out_o(mon[0]), .boost_en_o(mon[1]), .boost_zcd_o(mon[2]),
        .clamp_drive_o(mon[3]), .dim_level_o(dim), .boost_overvoltage_fault_o(mon[4]),
        .clamp_overpower_fault_o(mon[5]), .output_overvoltage_fault_o(mon[6]),
        .overcurrent_fault_o(mon[7]), .open_loop_fault_o(mon[8]), .die_overtemp_fault_o(mon[9]));

    lds_power_model pm (.mclk_i(mclk_i), .gate_i(mon[0]), .no_current_i(no_cur), .on_len_i(8'h0a),
        .dm_len_i(8'h0a), .cs_peak_o(cs_peak), .above_min_o(above_min), .demag_done_o(demag_done));

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic complete_run();
        $display("Checks %0d, mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    always @(posedge mclk_i) begin
        cyc = cyc + 1;
        if (cyc == CEIL) begin
            err_total++;
            complete_run();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(negedge mclk_i);
    endtask

    task automatic wait_bit(input int idx, input logic val, input int lim, output int n);
        n = 0;
        while (mon[idx] !== val && n < lim) begin
            @(negedge mclk_i);
            n++;
        end
    endtask

    // High time plus low time of one whole switching cycle
    task automatic period(output int p);
        int n;
        wait_bit(0, 1'b0, 40000, n);
        wait_bit(0, 1'b1, 40000, n);
        wait_bit(0, 1'b0, 40000, n);
        wait_bit(0, 1'b1, 40000, p);
        p = p + n;
    endtask

    task automatic pulse_half();
        hline = 1'b1;
        tick(8);
        hline = 1'b0;
        tick(8);
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_boost_sense();
        int n;
        boost_aux = 1'b1;
        wait_bit(2, 1'b1, 8, n);
        check({mon[2], n <= 6}, 2'b11);
        boost_aux = 1'b0;
        wait_bit(2, 1'b0, 8, n);
        check(mon[2], 1'b0);
    endtask

    task automatic t_period();
        int f100, b100, fi;
        period(f50);
        ipk = 8'hc8;
        period(fi);
        ipk = 8'h64;
        check(fi > f50 + f50 / 2, 1'b1);
        gain = 8'h64;
        period(f100);
        topo = LDS_BUCK;
        period(b100);
        topo = LDS_FLYBACK;
        gain = 8'h32;
        check(f50 > 150, 1'b1);
        check(f100 > f50 + f50 / 2, 1'b1);
        check(b100 > f100 + f100 / 4, 1'b1);
    endtask

    task automatic t_open_loop();
        int n;
        wait_bit(0, 1'b0, 40000, n);
        no_cur = 1'b1;
        wait_bit(0, 1'b1, 40000, n);
        wait_bit(8, 1'b1, 1100, n);
        tick(1);
        check({n >= 990, n <= 1004, mon[0]}, 3'b110);
        no_cur = 1'b0;
        wait_bit(8, 1'b0, RESTART + 8, n);
        check(mon[8], 1'b0);
    endtask

    task automatic t_out_faults();
        int n;
        aux_high = 1'b1;
        tick(6);
        aux_high = 1'b0;
        check({mon[6], mon[0], mon[1]}, 3'b100);
        wait_bit(6, 1'b0, RESTART + 8, n);
        check({mon[6], n >= RESTART - 8}, 2'b01);
        wait_bit(0, 1'b1, 4, n);
        check(mon[0], 1'b1);
        cur_high = 1'b1;
        tick(6);
        cur_high = 1'b0;
        check({mon[7], mon[0]}, 2'b10);
        tick(RESTART - 20);
        cur_high = 1'b1;
        tick(6);
        cur_high = 1'b0;
        wait_bit(7, 1'b0, RESTART + 8, n);
        check({mon[7], n >= RESTART - 8}, 2'b01);
    endtask

    task automatic t_dim();
        int p;
        pulse_half();
        tick(12000);
        pulse_half();
        check(dim, 8'h05);
        cond = 1'b1;
        tick(10752);
        cond = 1'b0;
        tick(1248);
        pulse_half();
        check(dim, 8'h0a);
        period(p);
        check(p > f50 * 10, 1'b1);
    endtask

    task automatic t_boost_ovp();
        int n;
        boost_high = 1'b1;
        wait_bit(1, 1'b0, BOOST_AVG + 10, n);
        check({mon[1], mon[4], dim}, {2'b01, 8'hff});
        check({n >= BOOST_AVG, n <= BOOST_AVG + 6}, 2'b11);
        boost_high = 1'b0;
        wait_bit(0, 1'b0, 1000, n);
        wait_bit(0, 1'b1, 1000, n);
        check({mon[0], mon[1], dim}, {2'b10, 8'hff});
        tick(30);
        check(mon[1], 1'b0);
        boost_low = 1'b1;
        wait_bit(1, 1'b1, 10, n);
        check({mon[1], mon[4]}, 2'b10);
        boost_low = 1'b0;
        tick(6);
        check(dim, 8'h0a);
    endtask

    task automatic t_clamp();
        int n;
        clamp_high = 1'b1;
        wait_bit(3, 1'b1, 8, n);
        check(mon[3], 1'b1);
        wait_bit(5, 1'b1, CLAMP_AVG + 8, n);
        check(n <= CLAMP_AVG + 2, 1'b1);
        tick(2);
        check({mon[5], mon[1], mon[0]}, 3'b100);
        tick(10);
        check(mon[3], 1'b0);
        clamp_high = 1'b0;
        wait_bit(5, 1'b0, RESTART + 8, n);
        check(mon[5], 1'b0);
    endtask

    task automatic t_die_temp();
        int n;
        hot = 1'b1;
        cool = 1'b0;
        wait_bit(9, 1'b1, 8, n);
        tick(2);
        check({mon[9], mon[0], mon[1]}, 3'b100);
        hot = 1'b0;
        tick(20);
        check({mon[9], mon[0]}, 2'b10);
        cool = 1'b1;
        wait_bit(9, 1'b0, 8, n);
        check(mon[9], 1'b0);
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        tick(4);
        check({dim, mon}, {8'hff, 10'h000});
        srst_i = 1'b0;
        tick(2);
        check(mon[1:0], 2'b11);
        t_boost_sense();
        t_period();
        t_open_loop();
        t_out_faults();
        t_dim();
        t_boost_ovp();
        t_clamp();
        t_die_temp();
        complete_run();
    end
endmodule
